// File: include/tppc_defs.svh
// register indices, byte addresses, reset values and timing counts of the port pin control block
// assumes a 32-bit AXI4-Lite slave where each byte register sits in the low lane of one word
`ifndef TPPC_DEFS_SVH
`define TPPC_DEFS_SVH

`define TPPC_ADDR_W 8
`define TPPC_IDX_T_DIR 6'h02
`define TPPC_IDX_T_DRV 6'h03
`define TPPC_IDX_T_PE 6'h04
`define TPPC_IDX_T_POL 6'h05
`define TPPC_IDX_U_DATA 6'h28
`define TPPC_IDX_U_PIN 6'h29
`define TPPC_IDX_U_DIR 6'h2a
`define TPPC_IDX_U_DRV 6'h2b
`define TPPC_IDX_U_PE 6'h2c
`define TPPC_IDX_U_POL 6'h2d
`define TPPC_IDX_ROUTE 6'h2e
`define TPPC_BYTE_ADDR(i) ({(i), 2'b00})
`define TPPC_RST_REG 8'h00
`define TPPC_RST_ROUTE 4'h0
`define TPPC_RESP_OKAY 2'b00
`define TPPC_RESP_SLVERR 2'b10
`define TPPC_SYNC_STAGES 2
`define TPPC_TIM_CH 4
`define TPPC_MOD_CH 6

`endif

// File: include/tppc_pkg.sv
// types of the port pin control block: register select, pin drive pair and whole state
// assumes tppc_defs.svh gives the widths used here
`include "tppc_defs.svh"
`default_nettype none
package tppc_pkg;
    typedef enum {
        SEL_NONE, SEL_T_DIR, SEL_T_DRV, SEL_T_PE, SEL_T_POL, SEL_U_DATA,
        SEL_U_PIN, SEL_U_DIR, SEL_U_DRV, SEL_U_PE, SEL_U_POL, SEL_ROUTE
    } tppc_sel_e;

    typedef struct packed {
        logic oe;
        logic out;
    } tppc_pin_s;

    typedef struct packed {
        logic [7:0] t_dir, t_drv, t_pe, t_pol;
        logic [7:0] u_data, u_dir, u_drv, u_pe, u_pol;
        logic [3:0] route;
        logic [7:0] t_sync1, t_sync2, u_sync1, u_sync2;
        logic aw_have, w_have, w_lane0;
        logic [`TPPC_ADDR_W-1:0] wa;
        logic [7:0] wd;
        logic awready, wready, bvalid, arready, rvalid;
        logic [1:0] bresp, rresp;
        logic [7:0] rdata;
        logic [7:0] t_out, t_oe, t_rdr, t_pon, t_pdn;
        logic [7:0] u_out, u_oe, u_rdr, u_pon, u_pdn;
    } tppc_state_s;
endpackage : tppc_pkg
`default_nettype wire

// File: verilog/tppc_top.sv
// pin control for ports T and U: direction, drive, pulls, port U data and routing, on AXI4-Lite
// assumes timer and modulator inputs synchronous to mclk; pins are sampled through a synchroniser
//
// The implementer's own choice: register access over AXI4-Lite.
`include "tppc_defs.svh"
`default_nettype none
module tppc_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [`TPPC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`TPPC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // general-purpose level for port T outputs, held by the port T data logic elsewhere
    input wire logic [7:0] port_t_gpio_data,
    input wire logic timer_zero_en,
    input wire logic timer_one_en,
    input wire logic timer_two_en,
    input wire logic [`TPPC_TIM_CH-1:0] timer_zero_oc_mode,
    input wire logic [`TPPC_TIM_CH-1:0] timer_one_oc_mode,
    input wire logic [`TPPC_TIM_CH-1:0] timer_two_oc_mode,
    input wire logic [`TPPC_TIM_CH-1:0] timer_zero_compare_out,
    input wire logic [`TPPC_TIM_CH-1:0] timer_one_compare_out,
    input wire logic [`TPPC_TIM_CH-1:0] timer_two_compare_out,
    input wire logic [`TPPC_MOD_CH-1:0] modulator_channel_en,
    input wire logic [`TPPC_MOD_CH-1:0] modulator_channel_out,
    input wire logic [7:0] port_t_pins_in,
    output logic [7:0] port_t_pins_out,
    output logic [7:0] port_t_pins_oe,
    output logic [7:0] port_t_drive_reduced,
    output logic [7:0] port_t_pull_on,
    output logic [7:0] port_t_pull_down,
    output logic [7:0] port_t_pin_level,
    input wire logic [7:0] port_u_pins_in,
    output logic [7:0] port_u_pins_out,
    output logic [7:0] port_u_pins_oe,
    output logic [7:0] port_u_drive_reduced,
    output logic [7:0] port_u_pull_on,
    output logic [7:0] port_u_pull_down
);
    tppc_pkg::tppc_state_s s_r;
    tppc_pkg::tppc_state_s s_nxt;

    function automatic tppc_pkg::tppc_sel_e decode(input logic [`TPPC_ADDR_W-1:0] a);
        tppc_pkg::tppc_sel_e sel;
        sel = tppc_pkg::SEL_NONE;
        case (a)
            `TPPC_BYTE_ADDR(`TPPC_IDX_T_DIR): sel = tppc_pkg::SEL_T_DIR;
            `TPPC_BYTE_ADDR(`TPPC_IDX_T_DRV): sel = tppc_pkg::SEL_T_DRV;
            `TPPC_BYTE_ADDR(`TPPC_IDX_T_PE): sel = tppc_pkg::SEL_T_PE;
            `TPPC_BYTE_ADDR(`TPPC_IDX_T_POL): sel = tppc_pkg::SEL_T_POL;
            `TPPC_BYTE_ADDR(`TPPC_IDX_U_DATA): sel = tppc_pkg::SEL_U_DATA;
            `TPPC_BYTE_ADDR(`TPPC_IDX_U_PIN): sel = tppc_pkg::SEL_U_PIN;
            `TPPC_BYTE_ADDR(`TPPC_IDX_U_DIR): sel = tppc_pkg::SEL_U_DIR;
            `TPPC_BYTE_ADDR(`TPPC_IDX_U_DRV): sel = tppc_pkg::SEL_U_DRV;
            `TPPC_BYTE_ADDR(`TPPC_IDX_U_PE): sel = tppc_pkg::SEL_U_PE;
            `TPPC_BYTE_ADDR(`TPPC_IDX_U_POL): sel = tppc_pkg::SEL_U_POL;
            `TPPC_BYTE_ADDR(`TPPC_IDX_ROUTE): sel = tppc_pkg::SEL_ROUTE;
            default: sel = tppc_pkg::SEL_NONE;
        endcase
        return sel;
    endfunction : decode

    // a peripheral that owns the pin drives it; otherwise the direction bit decides
    function automatic tppc_pkg::tppc_pin_s pin_ctl(input logic dir, input logic gpio_val,
                                                     input logic periph_act, input logic periph_val);
        tppc_pkg::tppc_pin_s p;
        p.oe = periph_act | dir;
        p.out = periph_act ? periph_val : gpio_val;
        return p;
    endfunction : pin_ctl

    always_comb begin
        tppc_pkg::tppc_pin_s p;
        tppc_pkg::tppc_sel_e wsel;
        tppc_pkg::tppc_sel_e rsel;
        logic aw_take, w_take, do_write;
        logic [`TPPC_ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic lane0;
        logic tim_act, mod_act, use_mod;
        logic [7:0] rbyte;
        p = '0;
        wsel = tppc_pkg::SEL_NONE;
        rsel = tppc_pkg::SEL_NONE;
        tim_act = 1'b0;
        mod_act = 1'b0;
        use_mod = 1'b0;
        rbyte = 8'h00;
        aw_take = 1'b0;
        w_take = 1'b0;
        do_write = 1'b0;
        lane0 = 1'b0;
        waddr = '0;
        wbyte = 8'h00;
        s_nxt = s_r;

        // second stage reads only the first
        s_nxt.t_sync1 = port_t_pins_in;
        s_nxt.t_sync2 = s_r.t_sync1;
        s_nxt.u_sync1 = port_u_pins_in;
        s_nxt.u_sync2 = s_r.u_sync1;

        // write side: address and data may come in either order
        aw_take = s_axi_awvalid && s_r.awready;
        w_take = s_axi_wvalid && s_r.wready;
        if (aw_take) begin
            s_nxt.aw_have = 1'b1;
            s_nxt.wa = s_axi_awaddr;
        end
        if (w_take) begin
            s_nxt.w_have = 1'b1;
            s_nxt.wd = s_axi_wdata[7:0];
            s_nxt.w_lane0 = s_axi_wstrb[0];
        end
        waddr = s_r.aw_have ? s_r.wa : s_axi_awaddr;
        wbyte = s_r.w_have ? s_r.wd : s_axi_wdata[7:0];
        lane0 = s_r.w_have ? s_r.w_lane0 : s_axi_wstrb[0];
        do_write = (s_r.aw_have || aw_take) && (s_r.w_have || w_take) && !s_r.bvalid;
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            wsel = decode(waddr);
            s_nxt.aw_have = 1'b0;
            s_nxt.w_have = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = (wsel == tppc_pkg::SEL_NONE) ? `TPPC_RESP_SLVERR : `TPPC_RESP_OKAY;
            // only the low byte lane carries a register
            if (lane0) begin
                case (wsel)
                    tppc_pkg::SEL_T_DIR: s_nxt.t_dir = wbyte;
                    tppc_pkg::SEL_T_DRV: s_nxt.t_drv = wbyte;
                    tppc_pkg::SEL_T_PE: s_nxt.t_pe = wbyte;
                    tppc_pkg::SEL_T_POL: s_nxt.t_pol = wbyte;
                    tppc_pkg::SEL_U_DATA: s_nxt.u_data = wbyte;
                    tppc_pkg::SEL_U_PIN: s_nxt.u_data = s_r.u_data;
                    tppc_pkg::SEL_U_DIR: s_nxt.u_dir = wbyte;
                    tppc_pkg::SEL_U_DRV: s_nxt.u_drv = wbyte;
                    tppc_pkg::SEL_U_PE: s_nxt.u_pe = wbyte;
                    tppc_pkg::SEL_U_POL: s_nxt.u_pol = wbyte;
                    tppc_pkg::SEL_ROUTE: s_nxt.route = wbyte[3:0];
                    default: s_nxt.route = s_r.route;
                endcase
            end
        end
        s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
        s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

        // read side: one outstanding read, answered the cycle after it is taken
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arready) begin
            rsel = decode(s_axi_araddr);
            case (rsel)
                tppc_pkg::SEL_T_DIR: rbyte = s_r.t_dir;
                tppc_pkg::SEL_T_DRV: rbyte = s_r.t_drv;
                tppc_pkg::SEL_T_PE: rbyte = s_r.t_pe;
                tppc_pkg::SEL_T_POL: rbyte = s_r.t_pol;
                tppc_pkg::SEL_U_DATA: rbyte = (s_r.u_dir & s_r.u_data) | (~s_r.u_dir & s_r.u_sync2);
                tppc_pkg::SEL_U_PIN: rbyte = s_r.u_sync2;
                tppc_pkg::SEL_U_DIR: rbyte = s_r.u_dir;
                tppc_pkg::SEL_U_DRV: rbyte = s_r.u_drv;
                tppc_pkg::SEL_U_PE: rbyte = s_r.u_pe;
                tppc_pkg::SEL_U_POL: rbyte = s_r.u_pol;
                tppc_pkg::SEL_ROUTE: rbyte = {4'h0, s_r.route};
                default: rbyte = 8'h00;
            endcase
            s_nxt.rdata = rbyte;
            s_nxt.rresp = (rsel == tppc_pkg::SEL_NONE) ? `TPPC_RESP_SLVERR : `TPPC_RESP_OKAY;
            s_nxt.rvalid = 1'b1;
        end
        s_nxt.arready = !s_nxt.rvalid;

        // port T: timer zero on pins 3:0, timer one on 7:4
        for (int i = 0; i < 8; i++) begin
            if (i < `TPPC_TIM_CH) begin
                tim_act = timer_zero_en && timer_zero_oc_mode[i];
                p = pin_ctl(s_r.t_dir[i], port_t_gpio_data[i], tim_act, timer_zero_compare_out[i]);
            end else begin
                tim_act = timer_one_en && timer_one_oc_mode[i-`TPPC_TIM_CH];
                p = pin_ctl(s_r.t_dir[i], port_t_gpio_data[i], tim_act, timer_one_compare_out[i-`TPPC_TIM_CH]);
            end
            s_nxt.t_oe[i] = p.oe;
            s_nxt.t_out[i] = p.out;
            s_nxt.t_rdr[i] = p.oe & s_r.t_drv[i];
            s_nxt.t_pon[i] = !p.oe & s_r.t_pe[i];
            s_nxt.t_pdn[i] = !p.oe & s_r.t_pe[i] & s_r.t_pol[i];
        end

        // port U: timer two on pins 3:0, modulator on 5:0, routing settles the overlap
        for (int i = 0; i < 8; i++) begin
            tim_act = (i < `TPPC_TIM_CH) && timer_two_en && timer_two_oc_mode[i % `TPPC_TIM_CH];
            mod_act = (i < `TPPC_MOD_CH) && modulator_channel_en[i % `TPPC_MOD_CH];
            use_mod = mod_act && (!tim_act || s_r.route[i % `TPPC_TIM_CH]);
            p = pin_ctl(s_r.u_dir[i], s_r.u_data[i], tim_act || mod_act,
                        use_mod ? modulator_channel_out[i % `TPPC_MOD_CH]
                                : timer_two_compare_out[i % `TPPC_TIM_CH]);
            s_nxt.u_oe[i] = p.oe;
            s_nxt.u_out[i] = p.out;
            s_nxt.u_rdr[i] = p.oe & s_r.u_drv[i];
            s_nxt.u_pon[i] = !p.oe & s_r.u_pe[i];
            s_nxt.u_pdn[i] = !p.oe & s_r.u_pe[i] & s_r.u_pol[i];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = {24'h000000, s_r.rdata};
    assign port_t_pins_out = s_r.t_out;
    assign port_t_pins_oe = s_r.t_oe;
    assign port_t_drive_reduced = s_r.t_rdr;
    assign port_t_pull_on = s_r.t_pon;
    assign port_t_pull_down = s_r.t_pdn;
    assign port_t_pin_level = s_r.t_sync2;
    assign port_u_pins_out = s_r.u_out;
    assign port_u_pins_oe = s_r.u_oe;
    assign port_u_drive_reduced = s_r.u_rdr;
    assign port_u_pull_on = s_r.u_pon;
    assign port_u_pull_down = s_r.u_pdn;

    property p_t_dir_only;
        @(posedge mclk) disable iff (!rst_n)
        !timer_one_en |=> port_t_pins_oe[7:4] == $past(s_r.t_dir[7:4]);
    endproperty
    a_t_dir_only: assert property (p_t_dir_only) else $error("port T direction not from register");

    property p_t_force;
        @(posedge mclk) disable iff (!rst_n)
        (timer_zero_en && timer_zero_oc_mode[0]) |=>
            port_t_pins_oe[0] && (port_t_pins_out[0] == $past(timer_zero_compare_out[0]));
    endproperty
    a_t_force: assert property (p_t_force) else $error("compare channel not forced onto pin");

    property p_t_release;
        @(posedge mclk) disable iff (!rst_n)
        (timer_one_en && $fell(timer_one_oc_mode[3])) |=> port_t_pins_oe[7] == $past(s_r.t_dir[7]);
    endproperty
    a_t_release: assert property (p_t_release) else $error("direction not restored");

    property p_t_capture;
        @(posedge mclk) disable iff (!rst_n)
        (timer_zero_en && !timer_zero_oc_mode[1]) |=> port_t_pins_oe[1] == $past(s_r.t_dir[1]);
    endproperty
    a_t_capture: assert property (p_t_capture) else $error("capture pin ignores direction");

    property p_drive;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> port_u_drive_reduced == (port_u_pins_oe & $past(s_r.u_drv));
    endproperty
    a_drive: assert property (p_drive) else $error("reduced drive wrong");

    property p_pull;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> port_t_pull_on == (~port_t_pins_oe & $past(s_r.t_pe));
    endproperty
    a_pull: assert property (p_pull) else $error("pull enable wrong");

    property p_pol;
        @(posedge mclk) disable iff (!rst_n)
        1'b1 |=> port_u_pull_down == (port_u_pull_on & $past(s_r.u_pol));
    endproperty
    a_pol: assert property (p_pol) else $error("pull polarity wrong");

    property p_mod_pin;
        @(posedge mclk) disable iff (!rst_n)
        modulator_channel_en[5] |=> port_u_pins_oe[5] && (port_u_pins_out[5] == $past(modulator_channel_out[5]));
    endproperty
    a_mod_pin: assert property (p_mod_pin) else $error("modulator does not own pin");

    property p_route;
        @(posedge mclk) disable iff (!rst_n)
        (timer_two_en && timer_two_oc_mode[2] && modulator_channel_en[2]) |=>
            port_u_pins_oe[2] && (port_u_pins_out[2] == ($past(s_r.route[2]) ? $past(modulator_channel_out[2])
                                                                                : $past(timer_two_compare_out[2])));
    endproperty
    a_route: assert property (p_route) else $error("routing choice wrong");

    property p_reset;
        @(posedge mclk) !rst_n |-> (port_u_pins_oe == 8'h00) && (s_r.u_data == 8'h00);
    endproperty
    a_reset: assert property (p_reset) else $error("port U not idle in reset");

    property p_data_read;
        @(posedge mclk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `TPPC_BYTE_ADDR(`TPPC_IDX_U_DATA)) |=>
            s_axi_rvalid && s_axi_rdata[7:0] == (($past(s_r.u_dir) & $past(s_r.u_data)) |
                                                 (~$past(s_r.u_dir) & $past(s_r.u_sync2)));
    endproperty
    a_data_read: assert property (p_data_read) else $error("data read mix wrong");

    property p_pin_read;
        @(posedge mclk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `TPPC_BYTE_ADDR(`TPPC_IDX_U_PIN)) |=>
            s_axi_rvalid && s_axi_rdata[7:0] == $past(port_u_pins_in, 3);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("pin input read wrong");

    property p_sync;
        @(posedge mclk) disable iff (!rst_n)
        $past(rst_n, 2) |-> s_r.u_sync2 == $past(port_u_pins_in, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("synchroniser depth wrong");

    property p_c_route_mod;
        @(posedge mclk) disable iff (!rst_n)
        timer_two_en && timer_two_oc_mode[0] && modulator_channel_en[0] && s_r.route[0];
    endproperty
    c_route_mod: cover property (p_c_route_mod);

    property p_c_write;
        @(posedge mclk) disable iff (!rst_n)
        s_axi_bvalid && s_axi_bready && s_axi_bresp == `TPPC_RESP_OKAY;
    endproperty
    c_write: cover property (p_c_write);

    property p_c_read_err;
        @(posedge mclk) disable iff (!rst_n)
        s_axi_rvalid && s_axi_rready && s_axi_rresp == `TPPC_RESP_SLVERR;
    endproperty
    c_read_err: cover property (p_c_read_err);
endmodule : tppc_top
`default_nettype wire

// File: testbench/tppc_pin_model.sv
// pin model: wire level of ports t (bits 7:0) and u (bits 15:8)
// assumes a pin that is neither driven nor pulled follows ext from the bench
`default_nettype none
module tppc_pin_model (
    input wire logic [15:0] drv_out,
    input wire logic [15:0] drv_oe,
    input wire logic [15:0] pull_on,
    input wire logic [15:0] pull_down,
    input wire logic [15:0] ext,
    output logic [15:0] level
);
    timeunit 1ns;
    timeprecision 100ps;
    // the pad driver beats any pull
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (drv_oe[i]) begin
                level[i] = drv_out[i];
            end else if (pull_on[i]) begin
                level[i] = ~pull_down[i];
            end else begin
                level[i] = ext[i];
            end
        end
    end
endmodule : tppc_pin_model
`default_nettype wire

// File: testbench/test_timer_pwm_port_pin_control.sv
// self-checking bench of the port pin control block over AXI4-Lite
// assumes tppc_top and tppc_pin_model; outputs settle 1 cycle, pin reads lag 2 more
`include "tppc_defs.svh"
`default_nettype none
module test_timer_pwm_port_pin_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, timer_zero_en, timer_one_en, timer_two_en;
    logic [`TPPC_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, timer_zero_oc_mode, timer_one_oc_mode, timer_two_oc_mode;
    logic [3:0] timer_zero_compare_out, timer_one_compare_out, timer_two_compare_out;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] port_t_gpio_data, port_t_pins_in, port_t_pins_out, port_t_pins_oe, port_t_drive_reduced;
    logic [7:0] port_t_pull_on, port_t_pull_down, port_t_pin_level, port_u_pins_in, port_u_pins_out;
    logic [7:0] port_u_pins_oe, port_u_drive_reduced, port_u_pull_on, port_u_pull_down, t_ext, u_ext;
    logic [5:0] modulator_channel_en, modulator_channel_out;
    int err_total, num_checks;
    localparam logic [5:0] CFG [10] = '{`TPPC_IDX_T_DIR, `TPPC_IDX_T_DRV, `TPPC_IDX_T_PE, `TPPC_IDX_T_POL,
        `TPPC_IDX_U_DATA, `TPPC_IDX_U_DIR, `TPPC_IDX_U_DRV, `TPPC_IDX_U_PE, `TPPC_IDX_U_POL, `TPPC_IDX_ROUTE};
    tppc_top tppc_top_i (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port_t_gpio_data, .timer_zero_en, .timer_one_en, .timer_two_en, .timer_zero_oc_mode, .timer_one_oc_mode,
        .timer_two_oc_mode, .timer_zero_compare_out, .timer_one_compare_out, .timer_two_compare_out,
        .modulator_channel_en, .modulator_channel_out, .port_t_pins_in, .port_t_pins_out, .port_t_pins_oe,
        .port_t_drive_reduced, .port_t_pull_on, .port_t_pull_down, .port_t_pin_level, .port_u_pins_in,
        .port_u_pins_out, .port_u_pins_oe, .port_u_drive_reduced, .port_u_pull_on, .port_u_pull_down);
    tppc_pin_model tppc_pin_model_i (.drv_out({port_u_pins_out, port_t_pins_out}),
        .drv_oe({port_u_pins_oe, port_t_pins_oe}), .pull_on({port_u_pull_on, port_t_pull_on}),
        .pull_down({port_u_pull_down, port_t_pull_down}), .ext({u_ext, t_ext}),
        .level({port_u_pins_in, port_t_pins_in}));
    function automatic logic [7:0] ba(input logic [5:0] i);
        return `TPPC_BYTE_ADDR(i);
    endfunction : ba
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // entered just after a rising edge; aw and w offered together, taken in either order
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ah, wh;
        ah = 1'h0;
        wh = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(ah && wh)) begin
            @(posedge mclk);
            if (!ah && s_axi_awready === 1'h1) begin
                ah = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (!wh && s_axi_wready === 1'h1) begin
                wh = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        // bready stays high for the whole run, so back-to-back calls never toggle it in one step
        do @(posedge mclk); while (s_axi_bvalid !== 1'h1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask : axw
    task automatic axr(input string nm, input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge mclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'h1);
        chk(nm, ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask : axr
    task automatic reset_values;
        for (int i = 0; i < 10; i++) axr("reset", ba(CFG[i]), 32'h0, `TPPC_RESP_OKAY);
        chk("u_oe", 32'h0, {24'h0, port_u_pins_oe});
        chk("u_pull", 32'h0, {24'h0, port_u_pull_on});
    endtask : reset_values
    task automatic reg_access;
        logic [7:0] v;
        for (int i = 0; i < 10; i++) if (i != 4) axw(ba(CFG[i]), 8'h96 ^ 8'(i), `TPPC_RESP_OKAY);
        for (int i = 0; i < 10; i++) begin
            v = 8'h96 ^ 8'(i);
            if (i == 9) v = {4'h0, v[3:0]};
            if (i != 4) axr("cfg", ba(CFG[i]), {24'h0, v}, `TPPC_RESP_OKAY);
        end
        axw(8'hfc, 8'h5a, `TPPC_RESP_SLVERR);
        axr("unmapped", 8'hfc, 32'h0, `TPPC_RESP_SLVERR);
        axr("misaligned", 8'h09, 32'h0, `TPPC_RESP_SLVERR);
        for (int i = 0; i < 10; i++) if (i != 4) axw(ba(CFG[i]), 8'h00, `TPPC_RESP_OKAY);
    endtask : reg_access
    // pin 0 held low by a modulator while its stored bit is 1: data and pin reads must differ
    task automatic u_data_reads;
        axw(ba(`TPPC_IDX_U_DIR), 8'hff, `TPPC_RESP_OKAY);
        axr("u_data_rst", ba(`TPPC_IDX_U_DATA), 32'h0, `TPPC_RESP_OKAY);
        axw(ba(`TPPC_IDX_U_DATA), 8'ha5, `TPPC_RESP_OKAY);
        axw(ba(`TPPC_IDX_U_DIR), 8'h0f, `TPPC_RESP_OKAY);
        modulator_channel_en <= 6'h01;
        u_ext <= 8'h3c;
        repeat (5) @(posedge mclk);
        axr("u_data", ba(`TPPC_IDX_U_DATA), 32'h35, `TPPC_RESP_OKAY);
        axw(ba(`TPPC_IDX_U_PIN), 8'hff, `TPPC_RESP_OKAY);
        axr("u_pin", ba(`TPPC_IDX_U_PIN), 32'h34, `TPPC_RESP_OKAY);
    endtask : u_data_reads
    task automatic port_u_owner;
        axw(ba(`TPPC_IDX_U_DIR), 8'h00, `TPPC_RESP_OKAY);
        modulator_channel_en <= 6'h00;
        timer_two_en <= 1'h1;
        timer_two_oc_mode <= 4'h6;
        timer_two_compare_out <= 4'h2;
        repeat (3) @(posedge mclk);
        chk("u_oe_tim", 32'h06, {24'h0, port_u_pins_oe});
        chk("u_out_tim", 32'h02, {24'h0, port_u_pins_out & 8'h06});
        axw(ba(`TPPC_IDX_ROUTE), 8'h04, `TPPC_RESP_OKAY);
        modulator_channel_en <= 6'h3c;
        modulator_channel_out <= 6'h14;
        repeat (3) @(posedge mclk);
        chk("u_oe_both", 32'h3e, {24'h0, port_u_pins_oe});
        chk("u_out_mod", 32'h16, {24'h0, port_u_pins_out & 8'h3e});
        axw(ba(`TPPC_IDX_ROUTE), 8'h00, `TPPC_RESP_OKAY);
        repeat (3) @(posedge mclk);
        chk("u_out_timer_two", 32'h12, {24'h0, port_u_pins_out & 8'h3e});
        timer_two_en <= 1'h0;
        modulator_channel_en <= 6'h00;
        axw(ba(`TPPC_IDX_U_DIR), 8'h81, `TPPC_RESP_OKAY);
        repeat (3) @(posedge mclk);
        chk("u_oe_gpio", 32'h81, {24'h0, port_u_pins_oe});
    endtask : port_u_owner
    task automatic port_t_pins;
        axw(ba(`TPPC_IDX_T_DIR), 8'h3c, `TPPC_RESP_OKAY);
        port_t_gpio_data <= 8'h96;
        repeat (3) @(posedge mclk);
        chk("t_oe", 32'h3c, {24'h0, port_t_pins_oe});
        chk("t_out", 32'h14, {24'h0, port_t_pins_out & 8'h3c});
        timer_zero_en <= 1'h1;
        timer_zero_oc_mode <= 4'h5;
        timer_zero_compare_out <= 4'h4;
        timer_one_en <= 1'h1;
        timer_one_oc_mode <= 4'ha;
        timer_one_compare_out <= 4'ha;
        repeat (3) @(posedge mclk);
        chk("t_oe_tim", 32'hbd, {24'h0, port_t_pins_oe});
        chk("t_out_tim", 32'ha4, {24'h0, port_t_pins_out & 8'ha5});
        // pin 7 leaves output compare while its timer runs: direction bit 0 takes over
        timer_one_oc_mode <= 4'h2;
        repeat (3) @(posedge mclk);
        chk("t_oe_rel", 32'h3d, {24'h0, port_t_pins_oe});
        timer_zero_oc_mode <= 4'h0;
        timer_one_en <= 1'h0;
        repeat (3) @(posedge mclk);
        chk("t_oe_off", 32'h3c, {24'h0, port_t_pins_oe});
        axw(ba(`TPPC_IDX_T_DRV), 8'hff, `TPPC_RESP_OKAY);
        axw(ba(`TPPC_IDX_T_PE), 8'hff, `TPPC_RESP_OKAY);
        axw(ba(`TPPC_IDX_T_POL), 8'hf0, `TPPC_RESP_OKAY);
        timer_zero_oc_mode <= 4'h1;
        repeat (5) @(posedge mclk);
        chk("t_drv", 32'h3d, {24'h0, port_t_drive_reduced});
        chk("t_pull", 32'hc2, {24'h0, port_t_pull_on});
        chk("t_pdn", 32'hc0, {24'h0, port_t_pull_down & port_t_pull_on});
        chk("t_level", 32'h02, {24'h0, port_t_pin_level & 8'hc2});
    endtask : port_t_pins
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h05;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = 54'h0;
        s_axi_wstrb = 4'h1;
        {timer_zero_en, timer_one_en, timer_two_en, modulator_channel_en, modulator_channel_out} = 15'h0;
        {timer_zero_oc_mode, timer_one_oc_mode, timer_two_oc_mode} = 12'h0;
        {timer_zero_compare_out, timer_one_compare_out, timer_two_compare_out} = 12'h0;
        {port_t_gpio_data, t_ext, u_ext} = 24'h0;
        err_total = 0;
        num_checks = 0;
        repeat (20) @(posedge mclk);
        rst_n <= 1'h1;
        @(posedge mclk);
        reset_values();
        reg_access();
        u_data_reads();
        port_u_owner();
        port_t_pins();
        tally_and_finish();
    end
endmodule : test_timer_pwm_port_pin_control
`default_nettype wire
